// [pkg/csw_pkg.sv]
package csw_pkg;

	// ---------------------------------------------------------------
	// Register map (byte addresses, one word each)
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_DEV_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CAN_MODE = 8'h04;
	localparam logic [7:0] ADDR_SWK_STAT = 8'h08;
	localparam logic [7:0] ADDR_EFF_STAT = 8'h0C;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int STAT_ERR_BIT = 0;
	localparam int STAT_ARMED_BIT = 1;
	localparam int STAT_CFGVAL_BIT = 2;
	localparam int STAT_SIL_BIT = 3;
	localparam int STAT_WOKEN_BIT = 4;
	localparam int STAT_WAKEIRQ_BIT = 5;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [2:0] RST_CAN_MODE = 3'h0;
	localparam logic [1:0] RST_DEV_MODE = 2'h0;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;

	// ---------------------------------------------------------------
	// Transceiver mode codes
	// ---------------------------------------------------------------
	localparam logic [2:0] CM_OFF0 = 3'h0;
	localparam logic [2:0] CM_WK = 3'h1;
	localparam logic [2:0] CM_RXO = 3'h2;
	localparam logic [2:0] CM_NORM = 3'h3;
	localparam logic [2:0] CM_OFF4 = 3'h4;
	localparam logic [2:0] CM_SWK = 3'h5;
	localparam logic [2:0] CM_RXO_SWK = 3'h6;
	localparam logic [2:0] CM_NORM_SWK = 3'h7;

	// Device modes as written to the device control register.
	typedef enum logic [1:0] {
		CSW_DEV_NORMAL = 2'h0,
		CSW_DEV_STOP = 2'h1,
		CSW_DEV_SLEEP = 2'h2,
		CSW_DEV_RESTART = 2'h3
	} csw_dev_t;

	// Effective transceiver behaviour.
	typedef struct packed {
		logic on;
		logic rx_en;
		logic tx_en;
		logic wake_en;
		logic swk_en;
	} csw_eff_t;

endpackage

// [rtl/csw_mode_ctrl.sv]
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/100ps
// Notes on behaviour
// - Mode field writes are accepted only while the device is in Normal or Restart mode.
// - Codes: 0/4 off, 1 wake, 2 rx-only, 3 normal, 5-7 with selective wake.
// - Normal-with-wake transmits, receives, and the filter monitors and flags silence.
// - Wake frame in normal-with-wake raises interrupt, receive output stays quiet.
// - Receive-only-with-wake forwards bus data, keeps filter on, never drives bus.
// - Error flag zero means no failed config check and no counter overflow.
// - Normal mode readback gives programmed code; status gives effective mode.
// - Leaving Normal may rewrite low two code bits; top bit kept.
// - Stop with error clear keeps every programmed mode.
// - Stop with error set drops filtering for 5/6/7; stored code unchanged.
// - Sleep turns 2 and 3 into 1; 0 and 4 stay off.
// - Sleep rewrites 5/6/7 to 5; filtered if error clear, else plain wake.
// - Wake frame in Sleep enters Restart, clears config-valid, code reads 5.
// - After a bus wake, wake capability returns only after a code change or a Sleep entry.
// - Sleep entry with a woken transceiver rearms it automatically.
// - Enabling filtering checks config; pass clears error flag, fail sets it.
// - Armed flag sets when filtering is correctly enabled.
module csw_mode_ctrl (
	input wire logic pclk, // APB clock
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic bus_rx_pin, // Receiver data from the bus
	input wire logic wake_frame_pin, // Wake frame detected by the decoder
	input wire logic bus_wake_pin, // Plain wake pattern seen on the bus
	input wire logic counter_ovf_pin, // Frame error counter overflow
	input wire logic silence_pin, // Bus silence time expired
	input wire logic host_txd, // Transmit data from the host logic
	output logic rxd_out, // Receive data to the host
	output logic bus_tx_dom, // Drive the bus dominant
	output logic can_wake_irq, // Wake interrupt pulse
	output logic [2:0] eff_mode // Effective mode code
);

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// The flops reset high: the receive pin idles recessive, and a high start on an event
	// pin can only give a falling edge, which no detector acts on, so reset makes no event.
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	logic [4:0] sync_prev_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 5'h1F;
			sync2_q <= 5'h1F;
			sync_prev_q <= 5'h1F;
		end else begin
			sync1_q <= {bus_rx_pin, wake_frame_pin, bus_wake_pin, counter_ovf_pin, silence_pin};
			sync2_q <= sync1_q;
			sync_prev_q <= sync2_q;
		end
	end
	wire rx_s = sync2_q[4];
	wire wuf_ev = sync2_q[3] & ~sync_prev_q[3];
	wire wup_ev = sync2_q[2] & ~sync_prev_q[2];
	wire ovf_ev = sync2_q[1] & ~sync_prev_q[1];
	wire sil_ev = sync2_q[0] & ~sync_prev_q[0];

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	logic [2:0] can_mode_q;
	logic [2:0] can_mode_d;
	csw_pkg::csw_dev_t dev_q;
	csw_pkg::csw_dev_t dev_d;
	logic err_q;
	logic armed_q;
	logic cfgval_q;
	logic sil_q;
	logic woken_q;
	logic wirq_q;
	logic [2:0] eff_q;
	logic [2:0] eff_d;

	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire hit_dev = paddr == csw_pkg::ADDR_DEV_CTRL;
	wire hit_mode = paddr == csw_pkg::ADDR_CAN_MODE;
	wire hit_stat = paddr == csw_pkg::ADDR_SWK_STAT;
	wire hit_eff = paddr == csw_pkg::ADDR_EFF_STAT;
	wire mapped = hit_dev | hit_mode | hit_stat | hit_eff;
	wire in_normal = dev_q == csw_pkg::CSW_DEV_NORMAL;
	wire in_restart = dev_q == csw_pkg::CSW_DEV_RESTART;
	wire mode_wr = wr & hit_mode & (in_normal | in_restart);
	wire dev_wr = wr & hit_dev;
	wire stat_wr = wr & hit_stat;
	wire [2:0] new_code = pwdata[2:0];
	wire code_change = mode_wr & (new_code != can_mode_q);
	wire swk_req = new_code[2] & (new_code[1:0] != 2'h0);
	wire cfg_ok = cfgval_q | (stat_wr & pwdata[csw_pkg::STAT_CFGVAL_BIT]);
	wire [1:0] dev_req = pwdata[1:0];

	// Status: write one to clear error and silence, write one to set config-valid.
	wire [31:0] stat_rd = {26'h0, wirq_q, woken_q, sil_q, cfgval_q, armed_q, err_q};
	wire [31:0] rd_mux = hit_dev ? {30'h0, dev_q} :
		hit_mode ? {29'h0, can_mode_q} :
		hit_stat ? stat_rd :
		hit_eff ? {29'h0, eff_q} : csw_pkg::RD_ZERO;

	// Ready follows the setup cycle, so every access takes two cycles with no wait state.
	// Read data is captured at setup and held, which keeps it stable through the access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= csw_pkg::RD_ZERO;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata <= (psel & ~penable & ~pwrite) ? rd_mux : prdata;
		end
	end

	// ---------------------------------------------------------------
	// Device mode and mode field
	// ---------------------------------------------------------------
	wire go_stop = dev_wr & in_normal & (dev_req == 2'h1);
	wire go_sleep = dev_wr & in_normal & (dev_req == 2'h2);
	wire go_normal = dev_wr & (dev_req == 2'h0) & ~in_normal;
	wire sleep_wake = (dev_q == csw_pkg::CSW_DEV_SLEEP) & woken_q;

	always_comb begin
		dev_d = dev_q;
		can_mode_d = can_mode_q;
		if (go_stop) begin
			dev_d = csw_pkg::CSW_DEV_STOP;
		end else if (go_sleep) begin
			dev_d = csw_pkg::CSW_DEV_SLEEP;
			if (can_mode_q == csw_pkg::CM_RXO || can_mode_q == csw_pkg::CM_NORM) begin
				can_mode_d = csw_pkg::CM_WK;
			end else if (swk_code(can_mode_q)) begin
				can_mode_d = csw_pkg::CM_SWK;
			end
		end else if (sleep_wake) begin
			dev_d = csw_pkg::CSW_DEV_RESTART;
		end else if (go_normal) begin
			dev_d = csw_pkg::CSW_DEV_NORMAL;
		end else if (mode_wr) begin
			can_mode_d = new_code;
		end
	end

	function automatic logic swk_code(input logic [2:0] c);
		swk_code = c[2] & (c[1:0] != 2'h0);
	endfunction

	// ---------------------------------------------------------------
	// Error, armed, woken and silence flags
	// ---------------------------------------------------------------
	// Once woken, further frames are ignored until a rearm, so a burst gives one wake only.
	wire filt_live = armed_q & ~err_q & swk_code(can_mode_q);
	wire wake_hit = ~woken_q & ((filt_live & wuf_ev) | (eff_d[0] & ~filt_live & wup_ev) | (filt_live & ovf_ev));
	wire rearm = code_change | go_sleep;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dev_q <= csw_pkg::CSW_DEV_NORMAL;
			can_mode_q <= csw_pkg::RST_CAN_MODE;
			err_q <= 1'b0;
			armed_q <= 1'b0;
			cfgval_q <= 1'b0;
			sil_q <= 1'b0;
			woken_q <= 1'b0;
			wirq_q <= 1'b0;
			eff_q <= csw_pkg::RST_CAN_MODE;
		end else begin
			dev_q <= dev_d;
			can_mode_q <= can_mode_d;
			eff_q <= eff_d;
			if (mode_wr & swk_req & code_change) begin
				err_q <= ~cfg_ok;
				armed_q <= cfg_ok;
			end else if (filt_live & ovf_ev) begin
				err_q <= 1'b1;
				armed_q <= 1'b0;
			end else if (stat_wr & pwdata[csw_pkg::STAT_ERR_BIT] & cfg_ok) begin
				err_q <= 1'b0;
			end
			if (mode_wr & ~swk_req) begin
				armed_q <= 1'b0;
			end
			if (sleep_wake) begin
				cfgval_q <= 1'b0;
			end else if (stat_wr & pwdata[csw_pkg::STAT_CFGVAL_BIT]) begin
				cfgval_q <= 1'b1;
			end
			if (filt_live & sil_ev) begin
				sil_q <= 1'b1;
			end else if (wup_ev | (stat_wr & pwdata[csw_pkg::STAT_SIL_BIT])) begin
				sil_q <= 1'b0;
			end
			if (wake_hit) begin
				woken_q <= 1'b1;
			end else if (rearm) begin
				woken_q <= 1'b0;
			end
			if (wake_hit & ~in_restart & (dev_q != csw_pkg::CSW_DEV_SLEEP)) begin
				wirq_q <= 1'b1;
			end else if (stat_wr & pwdata[csw_pkg::STAT_WAKEIRQ_BIT]) begin
				wirq_q <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Effective mode
	// ---------------------------------------------------------------
	// Effective code keeps the code space; filtered codes collapse to plain ones when errored.
	wire [2:0] nf_code = swk_code(can_mode_q) ? {1'b0, can_mode_q[1:0]} : can_mode_q;
	always_comb begin
		eff_d = (can_mode_q == csw_pkg::CM_OFF4) ? csw_pkg::CM_OFF0 : nf_code;
		if (dev_q == csw_pkg::CSW_DEV_SLEEP || in_restart) begin
			if (can_mode_q == csw_pkg::CM_OFF0 || can_mode_q == csw_pkg::CM_OFF4) begin
				eff_d = csw_pkg::CM_OFF0;
			end else begin
				eff_d = (swk_code(can_mode_q) & ~err_q & ~woken_q) ? csw_pkg::CM_SWK : csw_pkg::CM_WK;
			end
		end else if (swk_code(can_mode_q) & ~err_q) begin
			eff_d = can_mode_q;
		end else if (swk_code(can_mode_q)) begin
			eff_d = {1'b0, can_mode_q[1:0]};
		end
	end

	// ---------------------------------------------------------------
	// Data path
	// ---------------------------------------------------------------
	// Sleep keeps both paths quiet whatever the code says; only the wake logic listens there.
	wire rx_on = eff_q[1] & (dev_q != csw_pkg::CSW_DEV_SLEEP);
	wire tx_on = (eff_q[1:0] == 2'h3) & (dev_q != csw_pkg::CSW_DEV_SLEEP);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxd_out <= 1'b1;
			bus_tx_dom <= 1'b0;
			can_wake_irq <= 1'b0;
			eff_mode <= csw_pkg::RST_CAN_MODE;
		end else begin
			rxd_out <= rx_on ? rx_s : 1'b1;
			bus_tx_dom <= tx_on & ~host_txd;
			can_wake_irq <= wake_hit & ~in_restart & (dev_q != csw_pkg::CSW_DEV_SLEEP);
			eff_mode <= eff_q;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	AST_MODE_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
		(dev_q == csw_pkg::CSW_DEV_STOP) && !go_normal |=> $stable(can_mode_q))
		else $error("mode field changed in stop");
	AST_SLEEP_MAP: assert property (@(posedge pclk) disable iff (!presetn)
		go_sleep && (can_mode_q == csw_pkg::CM_NORM) |=> can_mode_q == csw_pkg::CM_WK)
		else $error("sleep map of normal code wrong");
	AST_SLEEP_SWK: assert property (@(posedge pclk) disable iff (!presetn)
		go_sleep && (can_mode_q == csw_pkg::CM_NORM_SWK) |=> can_mode_q == csw_pkg::CM_SWK)
		else $error("sleep map of filtered code wrong");
	AST_MSB_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
		go_sleep || go_stop |=> can_mode_q[2] == $past(can_mode_q[2]))
		else $error("top mode bit changed");
	AST_STOP_ERR: assert property (@(posedge pclk) disable iff (!presetn)
		(dev_q == csw_pkg::CSW_DEV_STOP) && err_q |-> !eff_d[2])
		else $error("filtering left on with error");
	// Only a filtered sleep code can read back as 101; a plain wake keeps its own code.
	AST_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
		sleep_wake && can_mode_q[2] |=> in_restart && !cfgval_q && can_mode_q == csw_pkg::CM_SWK)
		else $error("restart entry wrong");
	AST_NO_TX_RXO: assert property (@(posedge pclk) disable iff (!presetn)
		eff_q == csw_pkg::CM_RXO_SWK |=> !bus_tx_dom)
		else $error("bus driven in receive-only");
	AST_REARM: assert property (@(posedge pclk) disable iff (!presetn)
		go_sleep && !wake_hit |=> !woken_q)
		else $error("sleep entry did not rearm");
	AST_CHECK: assert property (@(posedge pclk) disable iff (!presetn)
		mode_wr && swk_req && code_change |=> err_q == !$past(cfg_ok))
		else $error("config check result wrong");

	// ---------------------------------------------------------------
	// Checks on low-power entry
	// ---------------------------------------------------------------
	sequence s_sleep_filt;
		go_sleep && swk_code(can_mode_q) && !err_q && !wake_hit;
	endsequence
	AST_STOP_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
		go_stop |=> $stable(can_mode_q))
		else $error("stop entry changed the mode field");
	AST_STOP_FILT: assert property (@(posedge pclk) disable iff (!presetn)
		(dev_q == csw_pkg::CSW_DEV_STOP) && !err_q && swk_code(can_mode_q) |-> eff_d == can_mode_q)
		else $error("filtered code lost in stop");
	AST_SLEEP_FILT: assert property (@(posedge pclk) disable iff (!presetn)
		s_sleep_filt |-> ##2 eff_q == csw_pkg::CM_SWK)
		else $error("sleep entry did not keep filtering");
	AST_SLEEP_ERR: assert property (@(posedge pclk) disable iff (!presetn)
		go_sleep && swk_code(can_mode_q) && err_q |-> ##2 eff_q == csw_pkg::CM_WK)
		else $error("sleep entry kept filtering with error");

	// ---------------------------------------------------------------
	// Checks on wake, flags and data path
	// ---------------------------------------------------------------
	// A wake frame seen in Sleep must pass through the woken state into Restart.
	sequence s_sleep_wuf;
		(dev_q == csw_pkg::CSW_DEV_SLEEP) && filt_live && wuf_ev && !woken_q && !go_normal;
	endsequence
	sequence s_restart_entry;
		woken_q ##1 (in_restart && !cfgval_q);
	endsequence
	sequence s_normal_wuf;
		in_normal && filt_live && wuf_ev && !woken_q;
	endsequence
	AST_WUF_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
		s_sleep_wuf |=> s_restart_entry)
		else $error("wake frame in sleep did not restart");
	AST_WAKE_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
		s_normal_wuf |=> can_wake_irq && woken_q)
		else $error("wake frame in normal gave no interrupt");
	AST_IRQ_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
		can_wake_irq |=> !can_wake_irq)
		else $error("wake interrupt longer than one cycle");
	AST_WOKEN_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		woken_q && !rearm |=> woken_q)
		else $error("woken state left without rearm");
	AST_OVF_ERR: assert property (@(posedge pclk) disable iff (!presetn)
		filt_live && ovf_ev && !(mode_wr && swk_req && code_change) |=> err_q && !armed_q)
		else $error("counter overflow did not set error");
	AST_ARMED: assert property (@(posedge pclk) disable iff (!presetn)
		mode_wr && swk_req && code_change && cfg_ok |=> armed_q && !err_q)
		else $error("filtering not armed after good check");
	AST_SIL_SET: assert property (@(posedge pclk) disable iff (!presetn)
		filt_live && sil_ev |=> sil_q)
		else $error("silence flag not set");
	AST_TX_NORM: assert property (@(posedge pclk) disable iff (!presetn)
		(eff_q == csw_pkg::CM_NORM_SWK) && in_normal && !host_txd |=> bus_tx_dom)
		else $error("normal with filtering did not transmit");
	AST_RX_FWD: assert property (@(posedge pclk) disable iff (!presetn)
		(eff_q == csw_pkg::CM_RXO_SWK) && in_normal |=> rxd_out == $past(rx_s))
		else $error("receive-only with filtering did not forward");

endmodule

// [test/csw_bus_model.sv]
`timescale 1ns/100ps
module csw_bus_model (
	input wire logic pclk, // Bench clock
	input wire logic bus_tx_dom, // Transceiver drives the bus dominant
	input wire logic ext_dom, // Another node drives the bus dominant
	input wire logic wake_req, // Send one wake frame
	output logic bus_rx_pin, // Bus level seen by the receiver
	output logic wake_frame_pin // Decoder flags a wake frame
);
	logic [2:0] hold_q = 3'h0;

	// Wired-and bus: any dominant driver pulls the level low.
	assign bus_rx_pin = !(bus_tx_dom || ext_dom);
	// The flag is held a few cycles so that the synchroniser sees one clean rising edge.
	assign wake_frame_pin = (hold_q != 3'h0);

	always @(posedge pclk) begin
		if (wake_req) begin
			hold_q <= 3'h5;
		end else if (hold_q != 3'h0) begin
			hold_q <= hold_q - 3'h1;
		end
	end
endmodule

// [test/can_selective_wake_mode_control_bench.sv]
`timescale 1ns/100ps
module can_selective_wake_mode_control_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic bus_rx_pin, wake_frame_pin, counter_ovf_pin, host_txd, rxd_out, bus_tx_dom, can_wake_irq;
	logic ext_dom, wake_req, bus_wake_pin, silence_pin;
	logic [2:0] eff_mode;
	logic [32:0] eq[$];
	int num_errors = 0;
	int checks = 0;
	int irqs = 0;

	csw_mode_ctrl i_csw_mode_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus_rx_pin(bus_rx_pin), .wake_frame_pin(wake_frame_pin),
		.bus_wake_pin(bus_wake_pin), .counter_ovf_pin(counter_ovf_pin), .silence_pin(silence_pin),
		.host_txd(host_txd), .rxd_out(rxd_out), .bus_tx_dom(bus_tx_dom),
		.can_wake_irq(can_wake_irq), .eff_mode(eff_mode));
	csw_bus_model i_csw_bus_model (.pclk(pclk), .bus_tx_dom(bus_tx_dom), .ext_dom(ext_dom),
		.wake_req(wake_req), .bus_rx_pin(bus_rx_pin), .wake_frame_pin(wake_frame_pin));

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task check(input logic [32:0] seen, input logic [32:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task test_done;
		$display("comparisons %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Only the bits under the mask are compared; status flags fed by the bus are not predicted.
	task rd(input logic [7:0] a, input logic [32:0] d, input logic [32:0] m = 33'h0_FFFF_FFFF);
		eq.push_back(d & m);
		eq.push_back(m);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	task wrm(input logic [2:0] c);
		apb(1'b1, csw_pkg::ADDR_CAN_MODE, {29'($urandom()), c});
	endtask

	task wait_bus;
		repeat (10) @(posedge pclk);
	endtask

	task wake;
		wake_req <= 1'b1;
		@(posedge pclk);
		wake_req <= 1'b0;
		repeat (14) @(posedge pclk);
	endtask

	function automatic logic [2:0] sleep_code(logic [2:0] c);
		return c[2] ? ((c == 3'h4) ? c : 3'h5) : ((c == 3'h0) ? c : 3'h1);
	endfunction

	function automatic logic [2:0] eff_of(logic [2:0] c);
		return (c == 3'h4) ? 3'h0 : c;
	endfunction

	// ---------------------------------------------------------------
	// Monitor and clock
	// ---------------------------------------------------------------
	always @(posedge pclk) begin
		logic [32:0] e;
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			e = eq.pop_front();
			check({pslverr, prdata} & eq.pop_front(), e);
		end
		if (can_wake_irq === 1'b1) begin
			irqs++;
		end
	end

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		repeat (6000) @(posedge pclk);
		num_errors++;
		test_done;
	end

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, counter_ovf_pin, ext_dom, wake_req, bus_wake_pin, silence_pin} = '0;
		{paddr, pwdata} = '0;
		host_txd = 1'b1;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		void'($urandom(20));
		rd(csw_pkg::ADDR_DEV_CTRL, 33'h0);
		rd(csw_pkg::ADDR_CAN_MODE, 33'h0);
		rd(csw_pkg::ADDR_EFF_STAT, 33'h0);
		apb(1'b1, csw_pkg::ADDR_SWK_STAT, 32'h0000_0004);
		for (int i = 0; i < 8; i++) begin
			wrm(3'(i));
			rd(csw_pkg::ADDR_CAN_MODE, 33'(i));
			rd(csw_pkg::ADDR_EFF_STAT, 33'(eff_of(3'(i))));
			host_txd <= 1'b0;
			wait_bus;
			check(33'(bus_tx_dom), 33'(i == 3 || i == 7));
			host_txd <= 1'b1;
			ext_dom <= 1'($urandom());
			wait_bus;
			check(33'(rxd_out), 33'(i[1] ? !ext_dom : 1'b1));
			ext_dom <= 1'b0;
		end
		$display("test mode codes done");
		for (int i = 0; i < 16; i++) begin
			wrm(3'(i));
			apb(1'b1, csw_pkg::ADDR_DEV_CTRL, i[3] ? 32'h2 : 32'h1);
			wrm(3'(i) ^ 3'h2);
			rd(csw_pkg::ADDR_CAN_MODE, 33'(i[3] ? sleep_code(3'(i)) : 3'(i)));
			rd(csw_pkg::ADDR_EFF_STAT, 33'(eff_of(i[3] ? sleep_code(3'(i)) : 3'(i))));
			apb(1'b1, csw_pkg::ADDR_DEV_CTRL, 32'h0);
		end
		$display("test low power entry done");
		wrm(3'h7);
		wake;
		check(33'(irqs), 33'h1);
		check(33'(rxd_out), 33'h1);
		wake;
		check(33'(irqs), 33'h1);
		wrm(3'h3);
		wrm(3'h7);
		wake;
		check(33'(irqs), 33'h2);
		$display("test normal wake done");
		apb(1'b1, csw_pkg::ADDR_DEV_CTRL, 32'h2);
		rd(csw_pkg::ADDR_EFF_STAT, 33'h5);
		wake;
		rd(csw_pkg::ADDR_DEV_CTRL, 33'h3);
		rd(csw_pkg::ADDR_CAN_MODE, 33'h5);
		rd(csw_pkg::ADDR_SWK_STAT, 33'h0, 33'h5);
		wrm(3'h1);
		apb(1'b1, csw_pkg::ADDR_SWK_STAT, 32'h0000_0005);
		wrm(3'h5);
		apb(1'b1, csw_pkg::ADDR_DEV_CTRL, 32'h0);
		apb(1'b1, csw_pkg::ADDR_DEV_CTRL, 32'h2);
		rd(csw_pkg::ADDR_EFF_STAT, 33'h5);
		apb(1'b1, csw_pkg::ADDR_DEV_CTRL, 32'h0);
		$display("test sleep wake done");
		wrm(3'h1);
		bus_wake_pin <= 1'b1;
		wait_bus;
		bus_wake_pin <= 1'b0;
		wait_bus;
		check(33'(irqs), 33'h3);
		wrm(3'h7);
		rd(csw_pkg::ADDR_SWK_STAT, 33'h0, 33'h1);
		silence_pin <= 1'b1;
		wait_bus;
		silence_pin <= 1'b0;
		rd(csw_pkg::ADDR_SWK_STAT, 33'h8, 33'h8);
		bus_wake_pin <= 1'b1;
		wait_bus;
		bus_wake_pin <= 1'b0;
		rd(csw_pkg::ADDR_SWK_STAT, 33'h0, 33'h8);
		counter_ovf_pin <= 1'b1;
		wait_bus;
		counter_ovf_pin <= 1'b0;
		rd(csw_pkg::ADDR_SWK_STAT, 33'h1, 33'h1);
		apb(1'b1, csw_pkg::ADDR_DEV_CTRL, 32'h1);
		rd(csw_pkg::ADDR_CAN_MODE, 33'h7);
		rd(csw_pkg::ADDR_EFF_STAT, 33'h3);
		apb(1'b1, csw_pkg::ADDR_DEV_CTRL, 32'h0);
		apb(1'b1, csw_pkg::ADDR_DEV_CTRL, 32'h2);
		rd(csw_pkg::ADDR_CAN_MODE, 33'h5);
		rd(csw_pkg::ADDR_EFF_STAT, 33'h1);
		apb(1'b1, csw_pkg::ADDR_DEV_CTRL, 32'h0);
		rd(8'h10, 33'h1_0000_0000, 33'h1_0000_0000);
		$display("test error flag done");
		test_done;
	end
endmodule
